// ---- core/bms_boot_select.sv ----
// Boot mode selection: strap capture, flash mapping, selective
// signature check and bootstrap channel scan.
// Assumes straps and receive lines are asynchronous pins and the
// flash read port answers on the same clock.
`timescale 1ns/10ps
module bms_boot_select
    import bms_pkg::*;
#(
    parameter logic [23:0] SIG_ADDR0 = 24'h000100,
    parameter logic [23:0] SIG_ADDR1 = 24'h000102,
    parameter logic [23:0] KEY_ADDR  = 24'h000104,
    parameter logic [15:0] SIG_REF   = 16'h5aa5,
    parameter logic [15:0] KEY_LOADER = 16'h0001,
    parameter logic [15:0] KEY_UART  = 16'h0002,
    parameter logic [15:0] KEY_CAN   = 16'h0003
) (
    input  wire logic          clk_i,
    input  wire logic          rst_n_i,
    input  wire logic          ext_rst_n_i,
    input  wire logic          boot_select_high_bit_i,
    input  wire logic          boot_select_low_bit_i,
    input  wire logic          uart_receive_line_i,
    input  wire logic          can_receive_line_i,
    input  wire logic [15:0]   flash_rdata_i,
    input  wire logic          flash_ack_i,
    output logic               flash_rd_o,
    output logic [23:0]        flash_addr_o,
    output bms_map_t           map_o,
    output bms_mode_t          mode_o,
    output logic               sw_reset_o,
    output logic               uart_boot_o,
    output logic               can_boot_o,
    output logic               user_run_o,
    output logic               halted_o
);

    // ****************************************************************
    // Parameter checks and local widths
    // ****************************************************************
    localparam int CW = $clog2(DOM_CYC + 1);

    // Refuses timing and key codes that the sequencer cannot tell apart.
    if (START_CYC < 1 || START_CYC > DOM_CYC) begin : g_bad_timing
        $error("Start time must be between one cycle and DOM time.");
    end
    if (KEY_LOADER == KEY_UART || KEY_LOADER == KEY_CAN ||
        KEY_UART == KEY_CAN) begin : g_bad_keys
        $error("Key codes must all differ.");
    end

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [4:0] meta_q;
    logic [4:0] sync_q;
    logic       ext_prev_q;
    logic       ext_s;
    logic       rst_rise;
    logic [1:0] sel_s;

    // Two flops for the reset pin, both straps and both receive lines.
    // They reset to the idle level of every pin, so no false edge or
    // false low time is seen after reset.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= '1;
            sync_q <= '1;
        end else begin
            meta_q <= {ext_rst_n_i, boot_select_high_bit_i,
                       boot_select_low_bit_i, uart_receive_line_i,
                       can_receive_line_i};
            sync_q <= meta_q;
        end
    end

    assign ext_s = sync_q[4];
    assign sel_s = sync_q[3:2];

    // Remembers the synchronised reset level for edge detection.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ext_prev_q <= 1'b1;
        end else begin
            ext_prev_q <= ext_s;
        end
    end

    assign rst_rise = ext_s & ~ext_prev_q;

    // ****************************************************************
    // Line detectors
    // ****************************************************************
    bms_state_t      state_q;
    bms_state_t      state_d;
    logic [CW-1:0]   uart_cnt_q;
    logic [CW-1:0]   can_cnt_q;
    logic            uart_start;
    logic            can_dom;

    // Low-time counters that only run while the lines are scanned.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            uart_cnt_q <= '0;
            can_cnt_q  <= '0;
        end else if (state_q != S_SCAN) begin
            uart_cnt_q <= '0;
            can_cnt_q  <= '0;
        end else begin
            if (sync_q[1]) begin
                uart_cnt_q <= '0;
            end else if (!uart_start) begin
                uart_cnt_q <= uart_cnt_q + CW'(1);
            end
            if (sync_q[0]) begin
                can_cnt_q <= '0;
            end else if (!can_dom) begin
                can_cnt_q <= can_cnt_q + CW'(1);
            end
        end
    end

    assign uart_start = (uart_cnt_q == CW'(START_CYC));
    assign can_dom    = (can_cnt_q == CW'(DOM_CYC));

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    bms_mode_t  mode_q;
    bms_chan_t  chan_q;
    bms_chan_t  chan_d;
    logic [15:0] word0_q;
    logic        sig_ok;
    logic [15:0] key;

    assign key    = flash_rdata_i;
    assign sig_ok = ((word0_q ^ flash_rdata_i) == SIG_REF);

    // Next state and channel enables.
    always_comb begin
        state_d = state_q;
        chan_d  = chan_q;
        unique case (state_q)
            S_HOLD: begin
                if (rst_rise) begin
                    state_d = S_DECODE;
                end
            end
            S_DECODE: begin
                unique case (mode_q)
                    BMS_MODE_USER: state_d = S_USER;
                    BMS_MODE_STD: begin
                        state_d = S_SCAN;
                        chan_d  = '{uart_en: 1'b1, can_en: 1'b1};
                    end
                    BMS_MODE_SEL:  state_d = S_RD_SIG0;
                    BMS_MODE_RSVD: state_d = S_HALT;
                endcase
            end
            S_RD_SIG0: begin
                if (flash_ack_i) begin
                    state_d = S_RD_SIG1;
                end
            end
            S_RD_SIG1: begin
                if (flash_ack_i) begin
                    state_d = sig_ok ? S_SWRST : S_RD_KEY;
                end
            end
            S_SWRST: state_d = S_USER;
            S_RD_KEY: begin
                if (flash_ack_i) begin
                    state_d = S_SCAN;
                    if (key == KEY_LOADER) begin
                        chan_d = '{uart_en: 1'b1, can_en: 1'b1};
                    end else if (key == KEY_UART) begin
                        chan_d = '{uart_en: 1'b1, can_en: 1'b0};
                    end else if (key == KEY_CAN) begin
                        chan_d = '{uart_en: 1'b0, can_en: 1'b1};
                    end else begin
                        state_d = S_HALT;
                    end
                end
            end
            S_SCAN: begin
                if (uart_start && chan_q.uart_en) begin
                    state_d = S_UART;
                end else if (can_dom && chan_q.can_en) begin
                    state_d = S_CAN;
                end
            end
            S_UART, S_CAN, S_USER, S_HALT: state_d = state_q;
        endcase
        if (!ext_s) begin
            state_d = S_HOLD;
            chan_d  = '0;
        end
    end

    // State, enables and captured strap pattern.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= S_HOLD;
            chan_q  <= '0;
            mode_q  <= BMS_MODE_RSVD;
        end else begin
            state_q <= state_d;
            chan_q  <= chan_d;
            if (rst_rise) begin
                mode_q <= bms_mode_t'(sel_s);
            end
        end
    end

    // First signature word, kept for the combine step.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            word0_q <= '0;
        end else if (state_q == S_RD_SIG0 && flash_ack_i) begin
            word0_q <= flash_rdata_i;
        end
    end

    // ****************************************************************
    // Registered outputs, decoded from the next state
    // ****************************************************************
    function automatic logic [23:0] rd_addr(input bms_state_t s);
        unique case (s)
            S_RD_SIG0: rd_addr = SIG_ADDR0;
            S_RD_SIG1: rd_addr = SIG_ADDR1;
            S_RD_KEY:  rd_addr = KEY_ADDR;
            default:   rd_addr = ADDR_ZERO;
        endcase
    endfunction : rd_addr

    // Mapping, flash read port and status flags.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flash_rd_o   <= 1'b0;
            flash_addr_o <= ADDR_ZERO;
            map_o        <= '0;
            mode_o       <= BMS_MODE_RSVD;
            sw_reset_o   <= 1'b0;
            uart_boot_o  <= 1'b0;
            can_boot_o   <= 1'b0;
            user_run_o   <= 1'b0;
            halted_o     <= 1'b0;
        end else begin
            flash_rd_o   <= (state_d == S_RD_SIG0) ||
                            (state_d == S_RD_SIG1) ||
                            (state_d == S_RD_KEY);
            flash_addr_o <= rd_addr(state_d);
            map_o.data_from_user <= (state_d != S_HOLD);
            map_o.code_from_boot <= (state_d != S_HOLD) &&
                                    (state_d != S_USER) &&
                                    (state_d != S_HALT || 
                                     mode_q != BMS_MODE_RSVD) &&
                                    (mode_q != BMS_MODE_USER);
            mode_o       <= (state_d == S_DECODE) ? bms_mode_t'(sel_s)
                                                  : mode_q;
            sw_reset_o   <= (state_d == S_SWRST);
            uart_boot_o  <= (state_d == S_UART);
            can_boot_o   <= (state_d == S_CAN);
            user_run_o   <= (state_d == S_USER);
            halted_o     <= (state_d == S_HALT);
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i || !ext_s);

    chk_strap_capture: assert property (rst_rise |=> mode_q ==
        bms_mode_t'($past(sel_s))) else $error("Strap not captured.");
    chk_user_map: assert property (state_q == S_USER |->
        !map_o.code_from_boot && map_o.data_from_user)
        else $error("User mapping wrong.");
    chk_std_map: assert property ((state_q == S_SCAN &&
        mode_q == BMS_MODE_STD) |-> map_o.code_from_boot &&
        map_o.data_from_user) else $error("Loader mapping wrong.");
    chk_sel_fetch: assert property (state_q == S_RD_SIG0 |->
        map_o.code_from_boot && flash_rd_o &&
        flash_addr_o == SIG_ADDR0) else $error("Selective fetch bad.");
    chk_sig_pass: assert property ((state_q == S_RD_SIG1 &&
        flash_ack_i && sig_ok) |=> sw_reset_o ##1
        (user_run_o && !sw_reset_o)) else $error("Pass path wrong.");
    chk_sig_fail: assert property ((state_q == S_RD_SIG1 &&
        flash_ack_i && !sig_ok) |=> flash_rd_o &&
        flash_addr_o == KEY_ADDR) else $error("Key not read.");
    chk_key_halt: assert property ((state_q == S_RD_KEY &&
        flash_ack_i && key != KEY_LOADER && key != KEY_UART &&
        key != KEY_CAN) |=> halted_o) else $error("Bad key no halt.");
    chk_scan_idle: assert property (state_q == S_SCAN |->
        !uart_boot_o && !can_boot_o) else $error("Channel too early.");
    chk_uart_first: assert property ((state_q == S_SCAN &&
        uart_start && chan_q.uart_en) |=> uart_boot_o && !can_boot_o)
        else $error("UART start missed.");
    chk_can_first: assert property ((state_q == S_SCAN &&
        can_dom && chan_q.can_en && !(uart_start && chan_q.uart_en))
        |=> can_boot_o) else $error("CAN start missed.");
    chk_rsvd_halt: assert property ((state_q == S_DECODE &&
        mode_q == BMS_MODE_RSVD) |=> halted_o && !uart_boot_o &&
        !can_boot_o) else $error("Reserved pattern not halted.");

    cov_user: cover property (state_q == S_DECODE ##1 user_run_o);
    cov_pass: cover property (sw_reset_o ##1 user_run_o);
    cov_uart: cover property (state_q == S_SCAN ##1 uart_boot_o);
    cov_can:  cover property (state_q == S_SCAN ##1 can_boot_o);

endmodule : bms_boot_select

// ---- common/bms_pkg.sv ----
// Constants, types and carriers of the boot mode selection block.
// Assumes a single 20 MHz system clock and pin-level straps.
// Overview of operation
// - The two boot select bits are captured at the rising edge of the external reset input and decoded.
// - Pattern 11 selects user mode with user flash at address zero for code and data.
// - Pattern 10 selects the standard loader with code fetches from boot flash and user flash readable as data.
// - Pattern 01 selects selective boot with code fetches redirected to boot flash and the selective sequence run.
// - Selective boot computes a signature from two reserved flash words and compares it with a reference.
// - A passing signature gives a software reset and then user code runs from user flash.
// - A failing signature reads the user key, which picks the standard loader, UART only, CAN only or a halt loop.
// - The standard loader watches both the UART and CAN receive lines for a start condition or a dominant bit.
// - A UART start condition seen first starts UART bootstrap loading.
// - A valid dominant CAN bit seen first starts CAN bootstrap loading.
package bms_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int START_TIME_NS = 500;
    localparam int DOM_TIME_NS   = 1000;
    localparam int START_CYC     =
        (START_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DOM_CYC       =
        (DOM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ****************************************************************
    // Widths and addresses
    // ****************************************************************
    localparam int          BMS_AW    = 24;
    localparam int          BMS_DW    = 16;
    localparam logic [23:0] ADDR_ZERO = 24'h000000;

    // ****************************************************************
    // Types
    // ****************************************************************
    // Codes follow the strap pattern {high bit, low bit}.
    typedef enum logic [1:0] {
        BMS_MODE_RSVD,
        BMS_MODE_SEL,
        BMS_MODE_STD,
        BMS_MODE_USER
    } bms_mode_t;

    typedef enum logic [3:0] {
        S_HOLD, S_DECODE, S_RD_SIG0, S_RD_SIG1, S_SWRST, S_RD_KEY,
        S_SCAN, S_UART, S_CAN, S_USER, S_HALT
    } bms_state_t;

    typedef struct packed {
        logic code_from_boot;
        logic data_from_user;
    } bms_map_t;

    typedef struct packed {
        logic uart_en;
        logic can_en;
    } bms_chan_t;

endpackage : bms_pkg

// ---- verif/bms_flash_host.sv ----
// Partner model: the reserved flash words read by the boot selector.
// Assumes the selector holds a read request until the cycle after ack.
`timescale 1ns/10ps
module bms_flash_host
    import bms_pkg::*;
#(
    parameter logic [23:0] SIG_ADDR0 = 24'h000100,
    parameter logic [23:0] SIG_ADDR1 = 24'h000102,
    parameter logic [23:0] KEY_ADDR  = 24'h000104
) (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        flash_rd_i,
    input  wire logic [23:0] flash_addr_i,
    input  wire logic [15:0] sig0_i,
    input  wire logic [15:0] sig1_i,
    input  wire logic [15:0] key_i,
    output logic             flash_ack_o,
    output logic [15:0]      flash_rdata_o
);
    logic        gap_q;
    int unsigned cnt_q;
    int unsigned lat_q;

    // ****************************************************************
    // Read responder
    // ****************************************************************
    // Answers each read after a random wait; the cycle after an ack is
    // skipped because the old request still stands then. Data outside
    // an ack is noise, so a stale word can never pass for a good one.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flash_ack_o   <= 1'b0;
            flash_rdata_o <= 16'h0000;
            gap_q         <= 1'b0;
            cnt_q         <= 0;
            lat_q         <= 1;
        end else begin
            flash_ack_o   <= 1'b0;
            flash_rdata_o <= 16'($urandom());
            if (gap_q || !flash_rd_i) begin
                gap_q <= 1'b0;
                cnt_q <= 0;
            end else if (cnt_q + 1 >= lat_q) begin
                flash_ack_o <= 1'b1;
                // The system has programmed signature and key words.
                flash_rdata_o <= (flash_addr_i == SIG_ADDR0) ? sig0_i :
                                 (flash_addr_i == SIG_ADDR1) ? sig1_i :
                                 (flash_addr_i == KEY_ADDR)  ? key_i :
                                 16'($urandom());
                gap_q <= 1'b1;
                cnt_q <= 0;
                lat_q <= 1 + $urandom_range(4);
            end else begin
                cnt_q <= cnt_q + 1;
            end
        end
    end
endmodule : bms_flash_host

// ---- verif/boot_mode_selection_test.sv ----
// Self-checking bench of the boot selector with a flash partner.
// Assumes the selector's default addresses, reference and key codes.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin num_checks++; \
    if ((got) !== (ex)) begin miscompares++; \
    $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module boot_mode_selection_test;
    import bms_pkg::*;
    localparam logic [15:0] REF_SIG = 16'h5aa5;
    logic        clk       = 1'b0;
    logic        rst_n     = 1'b0;
    logic        ext_rst_n = 1'b0;
    logic        sel_hi    = 1'b1;
    logic        sel_lo    = 1'b1;
    logic        uart_rx   = 1'b1;
    logic        can_rx    = 1'b1;
    logic [15:0] sig0      = 16'h0000;
    logic [15:0] sig1      = 16'h0000;
    logic [15:0] key       = 16'h0000;
    logic [15:0] rdata;
    logic [23:0] addr;
    logic        ack, rd, sw_rst, uart_go, can_go, run, halt;
    bms_map_t    map;
    bms_mode_t   mode;
    int          miscompares = 0;
    int          num_checks  = 0;
    int          cyc         = 0;
    int          sw_cnt      = 0;

    // ****************************************************************
    // Instances
    // ****************************************************************
    bms_boot_select dut_u (
        .clk_i(clk), .rst_n_i(rst_n), .ext_rst_n_i(ext_rst_n),
        .boot_select_high_bit_i(sel_hi), .boot_select_low_bit_i(sel_lo),
        .uart_receive_line_i(uart_rx), .can_receive_line_i(can_rx),
        .flash_rdata_i(rdata), .flash_ack_i(ack), .flash_rd_o(rd),
        .flash_addr_o(addr), .map_o(map), .mode_o(mode),
        .sw_reset_o(sw_rst), .uart_boot_o(uart_go), .can_boot_o(can_go),
        .user_run_o(run), .halted_o(halt)
    );
    bms_flash_host flash_u (
        .clk_i(clk), .rst_n_i(rst_n), .flash_rd_i(rd),
        .flash_addr_i(addr), .sig0_i(sig0), .sig1_i(sig1), .key_i(key),
        .flash_ack_o(ack), .flash_rdata_o(rdata)
    );

    // ****************************************************************
    // Clock, pulse counter and watchdog
    // ****************************************************************
    // Free-running 20 MHz clock.
    initial begin
        forever #25 clk = ~clk;
    end

    // Counts software reset pulses and cuts a hang short.
    always @(posedge clk) begin
        cyc++;
        if (sw_rst === 1'b1) sw_cnt++;
        if (cyc == 6000) begin
            miscompares++;
            end_of_test();
        end
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic cycles(input int n);
        repeat (n) @(negedge clk);
    endtask : cycles

    // One external reset with straps {h,l}, then CAN low c cycles and
    // UART low u cycles; the expectations follow from the boot rules.
    task automatic boot(input int h, input int l, input int pass,
                        input int k, input int c, input int u);
        int m;
        int er;
        int eh;
        int eu;
        int ec;
        int em;
        sig0 = 16'($urandom());
        sig1 = sig0 ^ REF_SIG;
        if (pass == 0) sig1 = sig1 ^ 16'($urandom_range(1, 65535));
        key = 16'(k);
        ext_rst_n = 1'b0;
        sel_hi = h[0];
        sel_lo = l[0];
        sw_cnt = 0;
        cycles(5);
        ext_rst_n = 1'b1;
        cycles(6);
        // Late strap changes must not alter the mode.
        sel_hi = ~sel_hi;
        sel_lo = ~sel_lo;
        cycles(40);
        m = h * 2 + l;
        er = 0;
        eh = 0;
        eu = 0;
        ec = 0;
        em = 3;
        if (m == 3 || (m == 1 && pass != 0)) begin
            er = 1;
            em = 1;
        end else if (m == 0) begin
            eh = 1;
            em = 1;
        end else if (m == 2 || k == 1) begin
            eu = 1;
            ec = 1;
        end else if (k == 2) eu = 1;
        else if (k == 3) ec = 1;
        else eh = 1;
        `CHK("mode", 2'(m), mode)
        `CHK("map", 2'(em), map)
        `CHK("run", 1'(er), run)
        `CHK("halt", 1'(eh), halt)
        `CHK("sw_reset", (m == 1 && pass != 0), sw_cnt)
        can_rx = 1'b0;
        cycles(c);
        can_rx = 1'b1;
        cycles(3);
        uart_rx = 1'b0;
        cycles(u);
        uart_rx = 1'b1;
        cycles(5);
        ec = (ec != 0 && c >= 20) ? 1 : 0;
        eu = (eu != 0 && u >= 10 && ec == 0) ? 1 : 0;
        `CHK("can", 1'(ec), can_go)
        `CHK("uart", 1'(eu), uart_go)
    endtask : boot

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    // User, standard (UART, CAN, short pulses), selective pass, every key
    // outcome and the reserved pattern, in turn.
    initial begin
        void'($urandom(32'hc1ef));
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        cycles(2);
        boot(1, 1, 0, 0, 25, 12);
        boot(1, 0, 0, 0, 5, 12);
        boot(1, 0, 0, 0, 25, 12);
        boot(1, 0, 0, 0, 19, 9);
        boot(0, 1, 1, 0, 25, 12);
        for (int k = 1; k <= 4; k++) begin
            boot(0, 1, 0, (k == 4) ? 7 : k, 25, 12);
        end
        boot(0, 0, 0, 0, 25, 12);
        end_of_test();
    end
endmodule : boot_mode_selection_test
